// [pkg/cmb_consts.svh]
// constants for the can message buffer register set: offsets, field positions, counts
// assumes a 4-bit word address and 16-bit register data on the software port
`ifndef CMB_CONSTS_SVH
`define CMB_CONSTS_SVH

`define CMB_ADDR_W 4
`define CMB_DATA_W 16

`define CMB_OFS_ID_LOW 4'h0
`define CMB_OFS_ID_HIGH 4'h1
`define CMB_OFS_CONFIG 4'h2
`define CMB_OFS_LENGTH 4'h3
`define CMB_OFS_CONTROL 4'h4
`define CMB_OFS_PAYLOAD_BASE 4'h8

`define CMB_CFG_OWS_BIT 7
`define CMB_CFG_RTR_BIT 6
`define CMB_CFG_TYPE_MSB 5
`define CMB_CFG_TYPE_LSB 3
`define CMB_CFG_ASSIGN_BIT 0

`define CMB_IDH_IDE_BIT 15
`define CMB_IDH_ID_MSB 12

`define CMB_TYPE_TX 3'h0
`define CMB_TYPE_RX_NOMASK 3'h1
`define CMB_TYPE_RX_LAST 3'h5

`define CMB_CTL_MUC_BIT 13
`define CMB_CTL_SET_IE_BIT 11
`define CMB_CTL_SET_TRQ_BIT 9
`define CMB_CTL_SET_RDY_BIT 8
`define CMB_FLAG_RDY 0
`define CMB_FLAG_TRQ 1
`define CMB_FLAG_DN 2
`define CMB_FLAG_IE 3
`define CMB_FLAG_MOW 4
`define CMB_FLAG_N 5

`define CMB_PAYLOAD_MAX 4'h8
`define CMB_STD_ID_MASK 29'h1FFC_0000
`define CMB_EXT_ID_MASK 29'h1FFF_FFFF

`endif

// [pkg/cmb_pkg.sv]
// types shared by the can message buffer design and its bench
// assumes cmb_consts.svh is on the include path
`include "cmb_consts.svh"

package cmb_pkg;

    typedef enum logic [2:0] {
        CMB_ST_IDLE = 3'b001,
        CMB_ST_STORE = 3'b010,
        CMB_ST_FINISH = 3'b100
    } cmb_store_state_t;

    // one frame offered by the protocol engine, already received in full
    typedef struct packed {
        logic ide;
        logic [28:0] id;
        logic remote;
        logic [3:0] dlc;
        logic [7:0][7:0] data;
        logic [28:0] care_mask;
    } cmb_rx_frame_t;

    // frame presented to the protocol engine for transmission
    typedef struct packed {
        logic request;
        logic remote;
        logic ide;
        logic [28:0] id;
        logic [3:0] dlc;
        logic [7:0][7:0] data;
    } cmb_tx_frame_t;

    typedef struct packed {
        logic cfg_ows;
        logic cfg_rtr;
        logic [2:0] cfg_type;
        logic cfg_assigned;
        logic id_ide;
        logic [28:0] id_val;
        logic [3:0] dlc;
        logic [7:0][7:0] payload;
        logic [4:0] flags;
        logic store_in_progress;
        cmb_store_state_t fsm;
        logic [3:0] byte_cnt;
        logic [3:0] byte_total;
        cmb_rx_frame_t frm;
        logic frm_remote;
        logic frm_mow;
        logic [15:0] rd_data;
        logic irq_pulse;
        logic hist_pulse;
    } cmb_state_t;

endpackage

// [rtl/cmb_pair_bit.sv]
// one control flag driven by a software set/clear pair and by hardware events
// assumes all inputs are on the same clock as the flag that holds the result
`timescale 1ns/1ps
`default_nettype none

module cmb_pair_bit (
    input wire logic cur_i,
    input wire logic sw_set_i,
    input wire logic sw_clr_i,
    input wire logic hw_set_i,
    input wire logic hw_clr_i,
    output logic next_o
);
    // a hardware set beats any clear so an event is never lost;
    // a software set beats a hardware clear so a fresh request survives
    always_comb begin
        if (hw_set_i) begin
            next_o = 1'b1;
        end else if (sw_set_i && !sw_clr_i) begin // RQ20
            next_o = 1'b1;
        end else if (hw_clr_i || (sw_clr_i && !sw_set_i)) begin // RQ20
            next_o = 1'b0;
        end else begin
            next_o = cur_i;
        end
    end
endmodule // cmb_pair_bit

`default_nettype wire

// [rtl/cmb_msg_buffer.sv]
// one can message buffer: configuration, identifier, length, payload and control
// registers, with the store sequencer that fills it from the protocol engine
// assumes the protocol engine and software port share clk_sys_i; matching masks
// arrive with each frame as a care mask
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cmb_consts.svh"

// Behaviour
// (RQ1) software writes zero to length register bits 7..4; they read zero
// (RQ2) store as many payload bytes as the length code says, at most 8
// (RQ3) replace policy 0 discards new data frame if stored flag set; 1 overwrites
// (RQ4) matching remote frame always stored when remote bit and transmit request are 0
// (RQ5) transmit buffer remote bit selects data frame (0) or remote frame (1)
// (RQ6) receiving a remote frame never alters the remote request bit
// (RQ7) remote bit 1 blocks storing a matching remote frame and all its effects
// (RQ8) type 0 transmit, 1 receive unmasked, 2..5 receive with mask 1..4
// (RQ9) only buffers with the assigned bit set transmit or receive
// (RQ10) software writes zero to configuration bits 2 and 1
// (RQ11) format bit picks 11-bit or 29-bit identifier; standard ignores low 18 bits
// (RQ12) software left-aligns a standard identifier into the top bits
// (RQ13) high identifier bits 14 and 13 are written zero; bit 15 is format
// (RQ14) control bit 13 reads 1 while a received frame is being stored
// (RQ15) overwrite status set on data overwrite, never on remote frame store
// (RQ16) interrupt enable gates reception and transmission completion interrupts
// (RQ17) stored flag reads 1 once a data or remote frame is stored
// (RQ18) transmit request reads 1 while transmission is pending or in progress
// (RQ19) set bits 11,9,8 and clear bits 4..0 in the control write layout
// (RQ20) set=1 clear=0 sets, set=0 clear=1 clears, else unchanged
// (RQ21) while ready is 1 only control flags take software writes; engine may store
// (RQ22) software sets ready before transmit request, and apart from interrupt enable
// (RQ23) software never sets the stored flag and writes zero to control bit 10
module cmb_msg_buffer (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [`CMB_ADDR_W-1:0] addr_i,
    input wire logic [`CMB_DATA_W-1:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    output logic [`CMB_DATA_W-1:0] rd_data_o,
    input wire logic rx_valid_i,
    input wire cmb_pkg::cmb_rx_frame_t rx_frame_i,
    output logic rx_ready_o,
    input wire logic tx_done_i,
    output cmb_pkg::cmb_tx_frame_t tx_frame_o,
    output logic completion_irq_o,
    output logic history_log_o
);
    cmb_pkg::cmb_state_t state_reg;
    cmb_pkg::cmb_state_t state_next;

    logic [4:0] flag_sw_set;
    logic [4:0] flag_sw_clr;
    logic [4:0] flag_hw_set;
    logic [4:0] flag_hw_clr;
    logic [4:0] flag_next;
    logic ctrl_wr;
    logic locked;
    logic is_tx_type;
    logic is_rx_type;
    logic [28:0] fmt_mask;
    logic id_match;
    logic take_base;
    logic take_remote;
    logic take_data;
    logic take_any;
    logic [3:0] rx_bytes;
    logic finishing;

    // while ready is set the buffer belongs to the engine
    assign locked = state_reg.flags[`CMB_FLAG_RDY]; // RQ21
    assign ctrl_wr = wr_en_i && (addr_i == `CMB_OFS_CONTROL);

    assign is_tx_type = (state_reg.cfg_type == `CMB_TYPE_TX); // RQ8
    assign is_rx_type = (state_reg.cfg_type >= `CMB_TYPE_RX_NOMASK) &&
                        (state_reg.cfg_type <= `CMB_TYPE_RX_LAST); // RQ8

    // standard format compares only the top eleven identifier bits
    assign fmt_mask = state_reg.id_ide ? `CMB_EXT_ID_MASK : `CMB_STD_ID_MASK; // RQ11
    assign id_match = (rx_frame_i.ide == state_reg.id_ide) &&
                      (((rx_frame_i.id ^ state_reg.id_val) & fmt_mask &
                        rx_frame_i.care_mask) == 29'h0000_0000); // RQ11

    // engine may store only into an assigned buffer that is ready and idle
    assign take_base = rx_valid_i && rx_ready_o && id_match &&
                       state_reg.cfg_assigned && locked; // RQ9
    assign take_remote = take_base && rx_frame_i.remote && (is_tx_type || is_rx_type) &&
                         !state_reg.cfg_rtr && !state_reg.flags[`CMB_FLAG_TRQ]; // RQ4 RQ7
    assign take_data = take_base && !rx_frame_i.remote && is_rx_type &&
                       (!state_reg.flags[`CMB_FLAG_DN] || state_reg.cfg_ows); // RQ3
    assign take_any = take_remote || take_data;

    // remote frames carry no payload whatever their length code says
    assign rx_bytes = rx_frame_i.remote ? 4'h0 :
                      ((rx_frame_i.dlc > `CMB_PAYLOAD_MAX) ? `CMB_PAYLOAD_MAX
                                                           : rx_frame_i.dlc); // RQ2

    assign rx_ready_o = (state_reg.fsm == cmb_pkg::CMB_ST_IDLE);
    assign finishing = (state_reg.fsm == cmb_pkg::CMB_ST_FINISH);

    // software side of each flag; interrupt enable is frozen while ready is set
    always_comb begin
        flag_sw_set = 5'h00;
        flag_sw_clr = 5'h00;
        if (ctrl_wr) begin
            flag_sw_set[`CMB_FLAG_RDY] = wr_data_i[`CMB_CTL_SET_RDY_BIT]; // RQ19
            flag_sw_set[`CMB_FLAG_TRQ] = wr_data_i[`CMB_CTL_SET_TRQ_BIT]; // RQ19
            flag_sw_set[`CMB_FLAG_IE] = wr_data_i[`CMB_CTL_SET_IE_BIT] && !locked; // RQ21
            flag_sw_clr[`CMB_FLAG_RDY] = wr_data_i[`CMB_FLAG_RDY]; // RQ19
            flag_sw_clr[`CMB_FLAG_TRQ] = wr_data_i[`CMB_FLAG_TRQ];
            flag_sw_clr[`CMB_FLAG_DN] = wr_data_i[`CMB_FLAG_DN];
            flag_sw_clr[`CMB_FLAG_IE] = wr_data_i[`CMB_FLAG_IE] && !locked; // RQ21
            flag_sw_clr[`CMB_FLAG_MOW] = wr_data_i[`CMB_FLAG_MOW];
        end
    end

    // hardware side: a finished store sets stored and maybe overwrite, a sent frame
    // ends the transmit request
    always_comb begin
        flag_hw_set = 5'h00;
        flag_hw_clr = 5'h00;
        flag_hw_set[`CMB_FLAG_DN] = finishing; // RQ17
        flag_hw_set[`CMB_FLAG_MOW] = finishing && state_reg.frm_mow; // RQ15
        flag_hw_clr[`CMB_FLAG_TRQ] = tx_done_i && tx_frame_o.request; // RQ18
    end

    genvar gi;
    generate
        for (gi = 0; gi < `CMB_FLAG_N; gi = gi + 1) begin : g_flag
            cmb_pair_bit u_pair (
                .cur_i(state_reg.flags[gi]),
                .sw_set_i(flag_sw_set[gi]),
                .sw_clr_i(flag_sw_clr[gi]),
                .hw_set_i(flag_hw_set[gi]),
                .hw_clr_i(flag_hw_clr[gi]),
                .next_o(flag_next[gi])
            );
        end
    endgenerate

    always_comb begin
        state_next = state_reg;
        state_next.flags = flag_next; // RQ20
        state_next.irq_pulse = 1'b0;
        state_next.hist_pulse = 1'b0;
        state_next.rd_data = 16'h0000;

        // plain register writes land only while software owns the buffer
        if (wr_en_i && !locked) begin // RQ21
            unique case (addr_i)
                `CMB_OFS_ID_LOW: begin
                    state_next.id_val[15:0] = wr_data_i;
                end
                `CMB_OFS_ID_HIGH: begin
                    state_next.id_ide = wr_data_i[`CMB_IDH_IDE_BIT]; // RQ11
                    // bits 14..13 are not kept and read back as zero
                    state_next.id_val[28:16] = wr_data_i[`CMB_IDH_ID_MSB:0]; // RQ13
                end
                `CMB_OFS_CONFIG: begin
                    state_next.cfg_ows = wr_data_i[`CMB_CFG_OWS_BIT];
                    state_next.cfg_rtr = wr_data_i[`CMB_CFG_RTR_BIT]; // RQ5
                    state_next.cfg_type = wr_data_i[`CMB_CFG_TYPE_MSB:`CMB_CFG_TYPE_LSB];
                    state_next.cfg_assigned = wr_data_i[`CMB_CFG_ASSIGN_BIT]; // RQ9
                end
                `CMB_OFS_LENGTH: begin
                    state_next.dlc = wr_data_i[3:0]; // RQ1
                end
                default: begin
                    if (addr_i[3]) begin
                        state_next.payload[addr_i[2:0]] = wr_data_i[7:0];
                    end
                end
            endcase
        end

        // store sequencer: one payload byte per cycle, then commit the flags
        unique case (state_reg.fsm)
            cmb_pkg::CMB_ST_IDLE: begin
                if (take_any) begin
                    state_next.frm = rx_frame_i;
                    state_next.frm_remote = rx_frame_i.remote;
                    // a remote frame never counts as an overwrite
                    state_next.frm_mow = take_data && state_reg.flags[`CMB_FLAG_DN]; // RQ15
                    state_next.byte_cnt = 4'h0;
                    state_next.byte_total = rx_bytes; // RQ2
                    state_next.store_in_progress = 1'b1; // RQ14
                    state_next.fsm = (rx_bytes == 4'h0) ? cmb_pkg::CMB_ST_FINISH
                                                        : cmb_pkg::CMB_ST_STORE;
                end
            end
            cmb_pkg::CMB_ST_STORE: begin
                state_next.payload[state_reg.byte_cnt[2:0]] =
                    state_reg.frm.data[state_reg.byte_cnt[2:0]]; // RQ2
                state_next.byte_cnt = state_reg.byte_cnt + 4'h1;
                if (state_reg.byte_cnt + 4'h1 == state_reg.byte_total) begin
                    state_next.fsm = cmb_pkg::CMB_ST_FINISH;
                end
            end
            cmb_pkg::CMB_ST_FINISH: begin
                state_next.dlc = state_reg.frm.dlc; // RQ4
                // receive buffers of every type 1..5, masked or unmasked, keep the identifier that arrived
                if (is_rx_type) begin
                    state_next.id_ide = state_reg.frm.ide;
                    state_next.id_val = state_reg.frm.id;
                end
                // the remote request bit is left exactly as software set it
                state_next.cfg_rtr = state_reg.cfg_rtr; // RQ6
                state_next.irq_pulse = state_reg.flags[`CMB_FLAG_IE]; // RQ16 RQ4
                state_next.hist_pulse = 1'b1; // RQ4
                state_next.store_in_progress = 1'b0; // RQ14
                state_next.fsm = cmb_pkg::CMB_ST_IDLE;
            end
            default: begin
                state_next.store_in_progress = 1'b0;
                state_next.fsm = cmb_pkg::CMB_ST_IDLE;
            end
        endcase

        // a completed transmission raises the same completion event when enabled
        if (tx_done_i && tx_frame_o.request && state_reg.flags[`CMB_FLAG_IE]) begin // RQ16
            state_next.irq_pulse = 1'b1;
        end

        // read data stand for one cycle; unmapped addresses read zero
        if (rd_en_i) begin
            unique case (addr_i)
                `CMB_OFS_ID_LOW: begin
                    state_next.rd_data = state_reg.id_val[15:0];
                end
                `CMB_OFS_ID_HIGH: begin
                    state_next.rd_data = {state_reg.id_ide, 2'b00,
                                          state_reg.id_val[28:16]}; // RQ13
                end
                `CMB_OFS_CONFIG: begin
                    state_next.rd_data = {8'h00, state_reg.cfg_ows, state_reg.cfg_rtr,
                                          state_reg.cfg_type, 2'b00,
                                          state_reg.cfg_assigned}; // RQ10
                end
                `CMB_OFS_LENGTH: begin
                    state_next.rd_data = {12'h000, state_reg.dlc}; // RQ1
                end
                `CMB_OFS_CONTROL: begin
                    state_next.rd_data = {2'b00, state_reg.store_in_progress, 8'h00,
                                          state_reg.flags}; // RQ14 RQ17 RQ18
                end
                default: begin
                    if (addr_i[3]) begin
                        state_next.rd_data = {8'h00, state_reg.payload[addr_i[2:0]]};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= '0;
            state_reg.fsm <= cmb_pkg::CMB_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rd_data_o = state_reg.rd_data;
    assign completion_irq_o = state_reg.irq_pulse;
    assign history_log_o = state_reg.hist_pulse;

    // only an assigned, ready transmit buffer with a pending request asks to send
    always_comb begin
        tx_frame_o.request = state_reg.cfg_assigned && is_tx_type && locked &&
                             state_reg.flags[`CMB_FLAG_TRQ]; // RQ9 RQ18
        tx_frame_o.remote = state_reg.cfg_rtr; // RQ5
        tx_frame_o.ide = state_reg.id_ide;
        tx_frame_o.id = state_reg.id_val & fmt_mask; // RQ11
        tx_frame_o.dlc = state_reg.dlc;
        tx_frame_o.data = state_reg.payload;
    end
endmodule // cmb_msg_buffer

`default_nettype wire

// [sim/cmb_msg_buffer_checker.sv]
// concurrent checks on the ports of one can message buffer
// assumes a single clock domain and the register map of cmb_consts.svh
`timescale 1ns/1ps
`default_nettype none
`include "cmb_consts.svh"

module cmb_msg_buffer_checker (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [`CMB_ADDR_W-1:0] addr_i,
    input wire logic [`CMB_DATA_W-1:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [`CMB_DATA_W-1:0] rd_data_o,
    input wire logic rx_valid_i,
    input wire cmb_pkg::cmb_rx_frame_t rx_frame_i,
    input wire logic rx_ready_o,
    input wire logic tx_done_i,
    input wire cmb_pkg::cmb_tx_frame_t tx_frame_o,
    input wire logic completion_irq_o,
    input wire logic history_log_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_read_idle_zero: assert property (!$past(rd_en_i) |-> rd_data_o == 16'h0000)
        else $error("read data not zero outside the read answer cycle");
    chk_ctrl_reserved: assert property ($past(rd_en_i) && $past(addr_i) == 4'h4
        |-> (rd_data_o & 16'hDFE0) == 16'h0000)
        else $error("control read shows reserved bits");
    chk_cfg_reserved: assert property ($past(rd_en_i) && $past(addr_i) == 4'h2
        |-> rd_data_o[15:8] == 8'h00 && rd_data_o[2:1] == 2'b00)
        else $error("configuration read shows reserved bits");
    chk_len_upper: assert property ($past(rd_en_i) && $past(addr_i) == 4'h3
        |-> rd_data_o[15:4] == 12'h000)
        else $error("length read shows upper bits");
    chk_idh_zero: assert property ($past(rd_en_i) && $past(addr_i) == 4'h1
        |-> rd_data_o[14:13] == 2'b00)
        else $error("high identifier bits 14 and 13 not zero");
    chk_std_id_low: assert property (!tx_frame_o.ide |-> tx_frame_o.id[17:0] == 18'h00000)
        else $error("standard identifier carries low bits");
    chk_hist_single: assert property (history_log_o |=> !history_log_o)
        else $error("history pulse longer than one cycle");
    chk_hist_after_busy: assert property (history_log_o |-> !$past(rx_ready_o))
        else $error("history pulse without a store in progress");
    chk_busy_cause: assert property ($fell(rx_ready_o) |-> $past(rx_valid_i))
        else $error("sequencer busy without an offered frame");
    chk_busy_bound: assert property ($fell(rx_ready_o) |-> ##[1:9] rx_ready_o)
        else $error("store lasted longer than eight bytes allow");
    chk_tx_done_clear: assert property (tx_done_i && tx_frame_o.request
        && !(wr_en_i && addr_i == 4'h4 && wr_data_i[9]) |=> !tx_frame_o.request)
        else $error("transmit request still set after completion");
    chk_irq_cause: assert property (completion_irq_o |-> history_log_o || $past(tx_done_i))
        else $error("completion pulse without store or transmit completion");

    cov_rx_irq: cover property (history_log_o && completion_irq_o);
    cov_tx_done: cover property (tx_done_i && tx_frame_o.request);
    cov_store: cover property ($fell(rx_ready_o));
endmodule // cmb_msg_buffer_checker

bind cmb_msg_buffer cmb_msg_buffer_checker chk_u (.clk_sys_i, .rst_n_i, .addr_i, .wr_data_i,
    .wr_en_i, .rd_en_i, .rd_data_o, .rx_valid_i, .rx_frame_i, .rx_ready_o, .tx_done_i,
    .tx_frame_o, .completion_irq_o, .history_log_o);

`default_nettype wire

// [sim/cmb_msg_buffer_test.sv]
// self-checking bench for one can message buffer: registers, receive store, transmit
// assumes the checker file is compiled alongside and binds itself to the design
`timescale 1ns/1ps
`default_nettype none
`include "cmb_consts.svh"

module cmb_msg_buffer_test;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wr_data_i = 16'h0000;
    logic wr_en_i = 1'b0;
    logic rd_en_i = 1'b0;
    logic [15:0] rd_data_o;
    logic rx_valid_i = 1'b0;
    cmb_pkg::cmb_rx_frame_t rx_frame_i = '0;
    logic rx_ready_o;
    logic tx_done_i = 1'b0;
    cmb_pkg::cmb_tx_frame_t tx_frame_o;
    logic completion_irq_o;
    logic history_log_o;
    int miscompares = 0;
    int checks_done = 0;
    int cnt;
    logic irq_seen;
    // address, write data, expected read back; later rows depend on earlier ones
    localparam logic [35:0] ROWS [16] = '{{4'h0, 16'hA5C3, 16'hA5C3}, {4'h1, 16'h9ABC, 16'h9ABC},
        {4'h2, 16'h00E9, 16'h00E9}, {4'h3, 16'h0008, 16'h0008}, {4'h8, 16'h0011, 16'h0011},
        {4'hF, 16'h00EE, 16'h00EE}, {4'h6, 16'h1234, 16'h0000}, {4'h4, 16'h0800, 16'h0008},
        {4'h4, 16'h0808, 16'h0008}, {4'h4, 16'h0008, 16'h0000}, {4'h4, 16'h0400, 16'h0000},
        {4'h4, 16'h0100, 16'h0001}, {4'h2, 16'h0000, 16'h00E9}, {4'h4, 16'h0800, 16'h0001},
        {4'h4, 16'h0200, 16'h0003}, {4'h4, 16'h0003, 16'h0000}};

    always #2.5 clk_sys_i = ~clk_sys_i;

    cmb_msg_buffer dut_u (.clk_sys_i, .rst_n_i, .addr_i, .wr_data_i, .wr_en_i, .rd_en_i,
        .rd_data_o, .rx_valid_i, .rx_frame_i, .rx_ready_o, .tx_done_i, .tx_frame_o,
        .completion_irq_o, .history_log_o);

    task automatic results();
        if (miscompares == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        wr_en_i <= 1'b1;
        addr_i <= a;
        wr_data_i <= d;
        @(posedge clk_sys_i);
        wr_en_i <= 1'b0;
    endtask

    task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_sys_i);
        rd_en_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_sys_i);
        rd_en_i <= 1'b0;
        #1;
        check(32'(rd_data_o), 32'(exp));
    endtask

    // offered only while the sequencer is idle, so the frame is taken at the second edge
    task automatic offer(input logic rem, input logic [28:0] id, input logic [3:0] dlc);
        @(posedge clk_sys_i);
        rx_frame_i <= '{ide: 1'b0, id: id, remote: rem, dlc: dlc,
            data: 64'h8877665544332211, care_mask: 29'h1FFFFFFF};
        rx_valid_i <= 1'b1;
        @(posedge clk_sys_i);
        rx_valid_i <= 1'b0;
    endtask

    // fixed span so the sequencer is idle again on return
    task automatic wait_hist(output int n, output logic irq);
        n = 0;
        irq = 1'b0;
        for (int i = 1; i <= 12; i++) begin
            @(posedge clk_sys_i);
            #1;
            if (history_log_o === 1'b1 && n == 0) begin
                n = i;
                irq = completion_irq_o;
            end
        end
    endtask

    task automatic rearm(input logic [15:0] cfg);
        wr(4'h4, 16'h0001);
        wr(4'h2, cfg);
        wr(4'h4, 16'h0100);
    endtask

    initial begin
        #50000;
        miscompares++;
        results();
    end

    initial begin
        repeat (10) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rdc(4'h4, 16'h0000);
        rdc(4'h2, 16'h0000);
        for (int r = 0; r < 16; r++) begin
            wr(ROWS[r][35:32], ROWS[r][31:16]);
            rdc(ROWS[r][35:32], ROWS[r][15:0]);
        end
        wr(4'h1, 16'h0123);
        wr(4'h2, 16'h0009);
        wr(4'h4, 16'h0800);
        wr(4'h4, 16'h0100);
        offer(1'b0, 29'h01205A5A, 4'h2);
        rdc(4'h4, 16'h2009);
        wait_hist(cnt, irq_seen);
        check(32'(cnt), 32'd1);
        check(32'(irq_seen), 32'd1);
        rdc(4'h4, 16'h000D);
        rdc(4'h3, 16'h0002);
        rdc(4'h9, 16'h0022);
        rdc(4'hF, 16'h00EE);
        offer(1'b0, 29'h01200000, 4'h8);
        wait_hist(cnt, irq_seen);
        check(32'(cnt), 32'd0);
        rdc(4'hF, 16'h00EE);
        rearm(16'h0089);
        offer(1'b0, 29'h01200000, 4'h9);
        wait_hist(cnt, irq_seen);
        check(32'(cnt), 32'd9);
        rdc(4'h4, 16'h001D);
        rdc(4'hF, 16'h0088);
        rearm(16'h0088);
        offer(1'b0, 29'h01200000, 4'h1);
        wait_hist(cnt, irq_seen);
        check(32'(cnt), 32'd0);
        // transmit side: clear every flag with the buffer unlocked first
        wr(4'h4, 16'h0001);
        wr(4'h4, 16'h001E);
        wr(4'h0, 16'hFFFF);
        wr(4'h1, 16'h1FFF);
        wr(4'h2, 16'h0041);
        wr(4'h4, 16'h0100);
        wr(4'h4, 16'h0200);
        #1;
        check(32'(tx_frame_o.request), 32'd1);
        check(32'(tx_frame_o.remote), 32'd1);
        check(32'(tx_frame_o.id), 32'h1FFC0000);
        offer(1'b1, 29'h1FFC1234, 4'h3);
        wait_hist(cnt, irq_seen);
        check(32'(cnt), 32'd0);
        rdc(4'h4, 16'h0003);
        @(posedge clk_sys_i);
        tx_done_i <= 1'b1;
        @(posedge clk_sys_i);
        tx_done_i <= 1'b0;
        #1;
        check(32'(tx_frame_o.request), 32'd0);
        check(32'(completion_irq_o), 32'd0);
        rearm(16'h0001);
        #1;
        check(32'(tx_frame_o.remote), 32'd0);
        for (int k = 0; k < 2; k++) begin
            offer(1'b1, 29'h1FFC1234, 4'h3);
            wait_hist(cnt, irq_seen);
            check(32'(cnt), 32'd1);
            rdc(4'h4, 16'h0005);
        end
        rdc(4'h2, 16'h0001);
        rdc(4'h3, 16'h0003);
        wr(4'h4, 16'h0004);
        rdc(4'h4, 16'h0001);
        rearm(16'h0000);
        wr(4'h4, 16'h0200);
        #1;
        check(32'(tx_frame_o.request), 32'd0);
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rdc(4'h4, 16'h0000);
        rdc(4'h2, 16'h0000);
        results();
    end
endmodule // cmb_msg_buffer_test

`default_nettype wire
